//--- hw/urc_channel.sv
// one uart channel: register file, transmitter, receiver and interrupt logic
// Notes on behaviour
// - line format bit 7 maps divisor at 0/1
// - offset 0 read returns receive buffer
// - offset 0 write loads transmit holding, unreadable
// - least significant bit goes first both ways
// - interrupt enable holds four enables, rest zero
// - ident bit0 low when pending, source, fifo bits
// - offset 2 write is fifo control
// - dma select bit has no effect
// - modem control fields, general outputs unpinned
// - fifo indications read zero without fifo mode
// - legacy mode: transmitter empty follows shift register
// - scratch byte absent in legacy mode
// - ident reads 01 after reset
// - line status interrupt outranks receive data
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module urc_channel
    import urc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // configuration
    input wire logic legacy_compat_in,
    // serial line and modem
    input wire logic rxd_in,
    output logic txd_out,
    output logic dtr_n_out,
    output logic rts_n_out,
    input wire logic cts_n_in,
    input wire logic dsr_n_in,
    input wire logic ri_n_in,
    input wire logic dcd_n_in,
    // interrupt
    output logic irq_out
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } urc_tx_type;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } urc_rx_type;

    logic [7:0] line_format_r;
    logic [3:0] irq_enable_r;
    logic [4:0] modem_control_r;
    logic [7:0] scratch_byte_r;
    logic [15:0] divisor_r;
    logic fifo_on_r;
    logic [1:0] trig_sel_r;
    logic tick;
    logic divisor_access_select;
    logic rd_data, wr_data, rd_iid;

    logic [7:0] txq [FIFO_DEPTH];
    logic [3:0] txq_wp_r, txq_rp_r;
    logic [4:0] txq_cnt_r;
    logic [7:0] rxq [FIFO_DEPTH];
    logic [3:0] rxq_wp_r, rxq_rp_r;
    logic [4:0] rxq_cnt_r;

    urc_tx_type tx_st_r;
    logic [3:0] tx_ovs_r;
    logic [2:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic tx_par_r, tx_stop2_r;
    urc_rx_type rx_st_r;
    logic [3:0] rx_ovs_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_par_r, rx_done_r;
    logic [2:0] rx_err_r;
    logic [2:0] rx_sync_r;
    logic rx_line, tx_line;

    logic overrun_r, tx_holding_empty_irq_r;
    logic [2:0] err_lat_r;
    logic [3:0] mdelta_r;
    logic [3:0] mline_r;
    logic [3:0] mline_in;
    logic [3:0] iid_code;
    logic [7:0] line_state;

    function automatic logic [2:0] last_bit(input logic [1:0] wl);
        last_bit = 3'(4 + wl);
    endfunction

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'b00: trig_level = 5'h01;
            2'b01: trig_level = 5'h04;
            2'b10: trig_level = 5'h08;
            2'b11: trig_level = 5'h0E;
        endcase
    endfunction

    assign divisor_access_select = line_format_r[LF_DIV_ACCESS];
    assign rd_data = rd_in && addr_in == OFS_DATA && !divisor_access_select;
    assign wr_data = wr_in && addr_in == OFS_DATA && !divisor_access_select;
    assign rd_iid = rd_in && addr_in == OFS_IID;

    urc_baud_gen u_baud (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .divisor_in(divisor_r),
        .tick_out(tick)
    );

    // configuration registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            line_format_r <= 8'h00;
            irq_enable_r <= 4'h0;
            modem_control_r <= 5'h00;
            scratch_byte_r <= 8'h00;
            divisor_r <= DIV_RESET;
            fifo_on_r <= 1'b0;
            trig_sel_r <= 2'b00;
        end else if (wr_in) begin
            unique case (addr_in)
                OFS_DATA: if (divisor_access_select) divisor_r[7:0] <= wdata_in;
                OFS_IEN: begin
                    if (divisor_access_select) begin
                        divisor_r[15:8] <= wdata_in;
                    end else begin
                        irq_enable_r <= wdata_in[3:0];
                    end
                end
                OFS_IID: begin
                    fifo_on_r <= wdata_in[FC_ENABLE];
                    trig_sel_r <= wdata_in[7:6];
                end
                OFS_LFMT: line_format_r <= wdata_in;
                OFS_MCTL: modem_control_r <= wdata_in[4:0];
                OFS_SCR: if (!legacy_compat_in) scratch_byte_r <= wdata_in;
                default: ;
            endcase
        end
    end

    // transmit queue, one entry when fifo mode is off
    logic tx_take;
    logic txq_clr;
    assign txq_clr = wr_in && addr_in == OFS_IID && (wdata_in[FC_TX_RST] || wdata_in[FC_ENABLE] != fifo_on_r);
    always_ff @(posedge clk_in) begin
        if (wr_data && txq_cnt_r < (fifo_on_r ? FIFO_FULL : 5'h01)) begin
            txq[txq_wp_r] <= wdata_in;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            txq_wp_r <= 4'h0;
            txq_rp_r <= 4'h0;
            txq_cnt_r <= 5'h00;
        end else if (txq_clr) begin
            txq_wp_r <= 4'h0;
            txq_rp_r <= 4'h0;
            txq_cnt_r <= 5'h00;
        end else begin
            if (wr_data && txq_cnt_r < (fifo_on_r ? FIFO_FULL : 5'h01)) begin
                txq_wp_r <= txq_wp_r + 4'h1;
            end
            if (tx_take) begin
                txq_rp_r <= txq_rp_r + 4'h1;
            end
            txq_cnt_r <= txq_cnt_r + 5'(wr_data && txq_cnt_r < (fifo_on_r ? FIFO_FULL : 5'h01)) - 5'(tx_take);
        end
    end

    // transmitter
    assign tx_take = tx_st_r == TX_IDLE && tick && txq_cnt_r != 5'h00;
    // internal serial level, also fed back in loopback while the pin stays marking
    assign tx_line = !line_format_r[LF_BREAK] && (tx_st_r == TX_START ? 1'b0 : (tx_st_r == TX_IDLE || tx_sh_r[0]));
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_st_r <= TX_IDLE;
            tx_ovs_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_par_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            txd_out <= 1'b1;
        end else begin
            txd_out <= tx_line || modem_control_r[MC_LOOP];
            if (tick) begin
                unique case (tx_st_r)
                    TX_IDLE: begin
                        if (tx_take) begin
                            tx_sh_r <= txq[txq_rp_r];
                            tx_st_r <= TX_START;
                            tx_ovs_r <= 4'h0;
                            tx_bit_r <= 3'h0;
                            tx_par_r <= 1'b0;
                            tx_stop2_r <= 1'b0;
                        end
                    end
                    TX_START: begin
                        tx_ovs_r <= tx_ovs_r + 4'h1;
                        if (tx_ovs_r == OVS_LAST) tx_st_r <= TX_DATA;
                    end
                    TX_DATA: begin
                        tx_ovs_r <= tx_ovs_r + 4'h1;
                        if (tx_ovs_r == OVS_LAST) begin
                            tx_par_r <= tx_par_r ^ tx_sh_r[0];
                            tx_sh_r <= {1'b1, tx_sh_r[7:1]};
                            tx_bit_r <= tx_bit_r + 3'h1;
                            if (tx_bit_r == last_bit(line_format_r[1:0])) begin
                                // bit0 of tx_bit_r marks a parity bit in flight
                                tx_sh_r <= {7'h7F, !line_format_r[LF_PAR_ON] || (line_format_r[LF_STICK] ?
                                    !line_format_r[LF_EVEN] : (tx_par_r ^ tx_sh_r[0] ^ !line_format_r[LF_EVEN]))};
                                tx_bit_r <= {2'b00, line_format_r[LF_PAR_ON]};
                                tx_stop2_r <= line_format_r[LF_STOP];
                                tx_st_r <= TX_STOP;
                            end
                        end
                    end
                    TX_STOP: begin
                        tx_ovs_r <= tx_ovs_r + 4'h1;
                        if (tx_ovs_r == OVS_LAST) begin
                            if (tx_bit_r[0]) begin
                                tx_bit_r <= 3'h0;
                                tx_sh_r <= 8'hFF;
                            end else if (tx_stop2_r) begin
                                tx_stop2_r <= 1'b0;
                            end else begin
                                tx_st_r <= TX_IDLE;
                            end
                        end
                    end
                    default: tx_st_r <= TX_IDLE;
                endcase
            end
        end
    end

    // receive line sampling with loopback
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_sync_r <= 3'b111;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], modem_control_r[MC_LOOP] ? tx_line : rxd_in};
        end
    end
    assign rx_line = rx_sync_r[2];

    // receiver
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_st_r <= RX_IDLE;
            rx_ovs_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_err_r <= 3'h0;
        end else begin
            rx_done_r <= 1'b0;
            if (tick) begin
                rx_ovs_r <= rx_ovs_r + 4'h1;
                unique case (rx_st_r)
                    RX_IDLE: begin
                        rx_ovs_r <= 4'h0;
                        if (!rx_line) rx_st_r <= RX_START;
                    end
                    RX_START: begin
                        if (rx_ovs_r == OVS_MID) begin
                            rx_ovs_r <= 4'h0;
                            rx_bit_r <= 3'h0;
                            rx_par_r <= 1'b0;
                            rx_sh_r <= 8'h00;
                            rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_ovs_r == OVS_LAST) begin
                            rx_sh_r[rx_bit_r] <= rx_line;
                            rx_par_r <= rx_par_r ^ rx_line;
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == last_bit(line_format_r[1:0])) rx_st_r <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_ovs_r == OVS_LAST) begin
                            if (line_format_r[LF_PAR_ON] && !rx_err_r[2]) begin
                                rx_err_r[0] <= line_format_r[LF_STICK] ? (rx_line == line_format_r[LF_EVEN]) :
                                    (rx_par_r ^ rx_line ^ !line_format_r[LF_EVEN]);
                                rx_err_r[2] <= 1'b1;
                            end else begin
                                rx_err_r[1] <= !rx_line;
                                rx_err_r[2] <= !rx_line && rx_sh_r == 8'h00;
                                rx_done_r <= 1'b1;
                                rx_st_r <= RX_IDLE;
                            end
                        end
                    end
                    default: rx_st_r <= RX_IDLE;
                endcase
                if (rx_st_r == RX_IDLE) rx_err_r <= 3'h0;
            end
        end
    end

    // receive queue of data bytes only; parity, framing and break flags latch in err_lat_r on push
    logic rxq_push, rxq_pop, rxq_clr;
    assign rxq_push = rx_done_r && rxq_cnt_r < (fifo_on_r ? FIFO_FULL : 5'h01);
    assign rxq_pop = rd_data && rxq_cnt_r != 5'h00;
    assign rxq_clr = wr_in && addr_in == OFS_IID && (wdata_in[FC_RX_RST] || wdata_in[FC_ENABLE] != fifo_on_r);
    always_ff @(posedge clk_in) begin
        if (rxq_push) begin
            rxq[rxq_wp_r] <= rx_sh_r;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rxq_wp_r <= 4'h0;
            rxq_rp_r <= 4'h0;
            rxq_cnt_r <= 5'h00;
        end else if (rxq_clr) begin
            rxq_wp_r <= 4'h0;
            rxq_rp_r <= 4'h0;
            rxq_cnt_r <= 5'h00;
        end else begin
            if (rxq_push) rxq_wp_r <= rxq_wp_r + 4'h1;
            if (rxq_pop) rxq_rp_r <= rxq_rp_r + 4'h1;
            rxq_cnt_r <= rxq_cnt_r + 5'(rxq_push) - 5'(rxq_pop);
        end
    end

    // sticky status: set wins over read clear
    assign mline_in = modem_control_r[MC_LOOP] ? {modem_control_r[3:2], modem_control_r[0], modem_control_r[1]} :
        {!dcd_n_in, !ri_n_in, !dsr_n_in, !cts_n_in};
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            overrun_r <= 1'b0;
            err_lat_r <= 3'h0;
            mdelta_r <= 4'h0;
            mline_r <= 4'h0;
            tx_holding_empty_irq_r <= 1'b0;
        end else begin
            mline_r <= mline_in;
            if (rx_done_r && !rxq_push) begin
                overrun_r <= 1'b1;
            end else if (rd_in && addr_in == OFS_LST) begin
                overrun_r <= 1'b0;
            end
            if (rxq_push) begin
                err_lat_r <= err_lat_r | rx_err_r;
            end else if (rd_in && addr_in == OFS_LST) begin
                err_lat_r <= 3'h0;
            end
            if (rd_in && addr_in == OFS_MST) begin
                mdelta_r <= {mline_r[3] ^ mline_in[3], mline_r[2] & !mline_in[2], mline_r[1] ^ mline_in[1], mline_r[0] ^ mline_in[0]};
            end else begin
                mdelta_r <= mdelta_r | {mline_r[3] ^ mline_in[3], mline_r[2] & !mline_in[2], mline_r[1] ^ mline_in[1], mline_r[0] ^ mline_in[0]};
            end
            if (tx_take && txq_cnt_r == 5'h01) begin
                tx_holding_empty_irq_r <= 1'b1;
            end else if (wr_data || rd_iid) begin
                tx_holding_empty_irq_r <= 1'b0;
            end
        end
    end

    // line state and interrupt priority
    always_comb begin
        line_state = {fifo_on_r && |err_lat_r,
                      legacy_compat_in ? tx_st_r == TX_IDLE : (tx_st_r == TX_IDLE && txq_cnt_r == 5'h00),
                      txq_cnt_r == 5'h00, err_lat_r[2], err_lat_r[1], err_lat_r[0], overrun_r, rxq_cnt_r != 5'h00};
        if (irq_enable_r[2] && |line_state[4:1]) begin
            iid_code = IID_LINE;
        end else if (irq_enable_r[0] && rxq_cnt_r >= (fifo_on_r ? trig_level(trig_sel_r) : 5'h01)) begin
            iid_code = IID_RXAV;
        end else if (irq_enable_r[1] && tx_holding_empty_irq_r) begin
            iid_code = IID_TXEM;
        end else if (irq_enable_r[3] && |mdelta_r) begin
            iid_code = IID_MODEM;
        end else begin
            iid_code = IID_NONE[3:0];
        end
    end

    // read data, modem pins and interrupt output
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
            irq_out <= 1'b0;
            dtr_n_out <= 1'b1;
            rts_n_out <= 1'b1;
        end else begin
            irq_out <= iid_code != IID_NONE[3:0];
            dtr_n_out <= !modem_control_r[0] || modem_control_r[MC_LOOP];
            rts_n_out <= !modem_control_r[1] || modem_control_r[MC_LOOP];
            rdata_out <= 8'h00;
            if (rd_in) begin
                unique case (addr_in)
                    OFS_DATA: rdata_out <= divisor_access_select ? divisor_r[7:0] : rxq[rxq_rp_r];
                    OFS_IEN: rdata_out <= divisor_access_select ? divisor_r[15:8] : {4'h0, irq_enable_r};
                    OFS_IID: rdata_out <= {{2{fifo_on_r}}, 2'b00, iid_code};
                    OFS_LFMT: rdata_out <= line_format_r;
                    OFS_MCTL: rdata_out <= {3'h0, modem_control_r};
                    OFS_LST: rdata_out <= line_state;
                    OFS_MST: rdata_out <= {mline_r, mdelta_r};
                    OFS_SCR: rdata_out <= legacy_compat_in ? 8'h00 : scratch_byte_r;
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end
endmodule

//--- hw/urc_pkg.sv
// package with register map, field positions and reset values of the uart channel
package urc_pkg;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_IID = 3'h2;
    localparam logic [2:0] OFS_LFMT = 3'h3;
    localparam logic [2:0] OFS_MCTL = 3'h4;
    localparam logic [2:0] OFS_LST = 3'h5;
    localparam logic [2:0] OFS_MST = 3'h6;
    localparam logic [2:0] OFS_SCR = 3'h7;
    localparam int LF_DIV_ACCESS = 7;
    localparam int LF_BREAK = 6;
    localparam int LF_STICK = 5;
    localparam int LF_EVEN = 4;
    localparam int LF_PAR_ON = 3;
    localparam int LF_STOP = 2;
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_RST = 1;
    localparam int FC_TX_RST = 2;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] IID_NONE = 8'h01;
    localparam logic [3:0] IID_LINE = 4'h6;
    localparam logic [3:0] IID_RXAV = 4'h4;
    localparam logic [3:0] IID_TXEM = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
    localparam logic [7:0] LST_RESET = 8'h60;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL = 5'h10;
endpackage

//--- hw/urc_baud_gen.sv
// baud generator producing one pulse per sixteenth of a bit
`timescale 1ns/1ps
module urc_baud_gen
    import urc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // divisor and tick
    input wire logic [15:0] divisor_in,
    output logic tick_out
);
    logic [15:0] count_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= 16'h0000;
            tick_out <= 1'b0;
        end else if (count_r + 16'h0001 >= divisor_in) begin
            count_r <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            count_r <= count_r + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule

//--- tb/urc_channel_asserts.sv
// checker for the uart channel register port and modem pins
`timescale 1ns/1ps
module urc_channel_asserts
    import urc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // configuration, modem and interrupt
    input wire logic legacy_compat_in,
    input wire logic dtr_n_out,
    input wire logic rts_n_out,
    input wire logic irq_out
);
    logic fe_r;
    logic [7:0] lf_r;
    logic [7:0] mc_r;
    logic [7:0] div_lo_r;
    // shadow copies of written registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fe_r <= 1'b0;
            lf_r <= 8'h00;
            mc_r <= 8'h00;
            div_lo_r <= DIV_RESET[7:0];
        end else if (wr_in) begin
            if (addr_in == OFS_IID) fe_r <= wdata_in[FC_ENABLE];
            if (addr_in == OFS_LFMT) lf_r <= wdata_in;
            if (addr_in == OFS_MCTL) mc_r <= wdata_in;
            if (addr_in == OFS_DATA && lf_r[LF_DIV_ACCESS]) div_lo_r <= wdata_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_div_low_read: assert property (rd_in && lf_r[LF_DIV_ACCESS] && addr_in == OFS_DATA |=> rdata_out == div_lo_r)
        else $error("divisor low byte read wrong");
    a_ien_upper_zero: assert property (rd_in && !lf_r[LF_DIV_ACCESS] && addr_in == OFS_IEN |=> rdata_out[7:4] == 4'h0)
        else $error("interrupt enable upper bits not zero");
    a_iid_fifo_bits: assert property (rd_in && addr_in == OFS_IID |=> rdata_out[7:4] == {{2{$past(fe_r)}}, 2'h0})
        else $error("ident upper bits wrong");
    a_iid_pending_low: assert property (rd_in && addr_in == OFS_IID |=> rdata_out[0] == !irq_out)
        else $error("ident pending bit disagrees with irq");
    a_lfmt_readback: assert property (rd_in && addr_in == OFS_LFMT |=> rdata_out == lf_r)
        else $error("line format readback wrong");
    a_mctl_upper_zero: assert property (rd_in && addr_in == OFS_MCTL |=> rdata_out == {3'h0, mc_r[4:0]})
        else $error("modem control readback wrong");
    a_scr_legacy_zero: assert property (rd_in && legacy_compat_in && addr_in == OFS_SCR |=> rdata_out == 8'h00)
        else $error("scratch readable in legacy mode");
    a_modem_pins: assert property ($stable(mc_r) |-> dtr_n_out == (!mc_r[0] || mc_r[MC_LOOP])
        && rts_n_out == (!mc_r[1] || mc_r[MC_LOOP])) else $error("modem pins do not follow control");
    cover property (rd_in && addr_in == OFS_IID && irq_out);
    cover property (fe_r && rd_in && addr_in == OFS_IID);
    cover property (legacy_compat_in && rd_in && addr_in == OFS_SCR);
endmodule

bind urc_channel urc_channel_asserts u_chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .legacy_compat_in, .dtr_n_out, .rts_n_out, .irq_out);

//--- tb/urc_peer_model.sv
// serial peer: sends frames on the receive line and collects one frame from the transmit line
`timescale 1ns/1ps
module urc_peer_model #(
    parameter int BIT_CYC = 16
) (
    // clock
    input wire logic clk_in,
    // serial lines
    input wire logic txd_in,
    output logic rxd_out,
    // captured byte
    output logic [7:0] got_out,
    output logic got_vld_out
);
    task automatic send(input logic [7:0] b, input logic bad_stop);
        logic [9:0] f;
        f = {~bad_stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_out <= f[i]; // bit 0 follows the start bit
            repeat ((i == 9 && bad_stop) ? BIT_CYC * 3 / 4 : BIT_CYC) @(posedge clk_in);
        end
        rxd_out <= 1'b1;
    endtask
    initial begin
        rxd_out = 1'b1;
        got_out = 8'h00;
        got_vld_out = 1'b0;
        @(negedge txd_in);
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_in);
            got_out[i] = txd_in; // first bit on the line is bit 0
        end
        got_vld_out = 1'b1;
    end
endmodule

//--- tb/urc_channel_tb.sv
// testbench for the uart channel: register access, serial traffic and interrupts
`timescale 1ns/1ps
module urc_channel_tb;
    import urc_pkg::*;
    logic clk_in, rst_in, wr_in, rd_in, legacy_compat_in, rxd_in, txd_out, dtr_n_out, rts_n_out, irq_out, got_vld;
    logic cts_n_in, dsr_n_in, ri_n_in, dcd_n_in;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, got, d;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    urc_channel uut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .legacy_compat_in,
        .rxd_in, .txd_out, .dtr_n_out, .rts_n_out, .cts_n_in, .dsr_n_in, .ri_n_in, .dcd_n_in, .irq_out);
    urc_peer_model u_peer (.clk_in, .txd_in(txd_out), .rxd_out(rxd_in), .got_out(got), .got_vld_out(got_vld));
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        v = rdata_out;
    endtask
    task automatic chk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        cmp(v, e);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 100 && irq_out !== 1'b1; i++) @(posedge clk_in);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        {rst_in, addr_in, wdata_in, wr_in, rd_in, legacy_compat_in} = {1'b1, 3'h0, 8'h00, 3'h0};
        {cts_n_in, dsr_n_in, ri_n_in, dcd_n_in} = 4'hF;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk(OFS_IID, IID_NONE);
        chk(OFS_LST, LST_RESET);
        wr(OFS_LFMT, 8'h83);
        wr(OFS_DATA, 8'h01);
        wr(OFS_IEN, 8'h00);
        chk(OFS_DATA, 8'h01);
        chk(OFS_IEN, 8'h00);
        chk(OFS_LFMT, 8'h83);
        wr(OFS_LFMT, 8'h03);
        wr(OFS_IEN, 8'hFF);
        chk(OFS_IEN, 8'h0F);
        wr(OFS_MCTL, 8'hE3);
        chk(OFS_MCTL, 8'h03);
        cmp({6'h00, dtr_n_out, rts_n_out}, 8'h00);
        wr(OFS_MCTL, 8'h1F);
        @(posedge clk_in);
        cmp({6'h00, dtr_n_out, rts_n_out}, 8'h03);
        wr(OFS_MCTL, 8'h00);
        chk(OFS_MST, 8'h0F);
        wr(OFS_SCR, 8'hA5);
        chk(OFS_SCR, 8'hA5);
        legacy_compat_in <= 1'b1;
        chk(OFS_SCR, 8'h00);
        chk(OFS_LST, 8'h60);
        legacy_compat_in <= 1'b0;
        wr(OFS_IEN, 8'h05);
        u_peer.send(8'hA1, 1'b0);
        wait_irq();
        cmp({7'h00, irq_out}, 8'h01);
        chk(OFS_IID, 8'h04);
        chk(OFS_LST, 8'h61);
        wr(OFS_IEN, 8'h00);
        @(posedge clk_in);
        cmp({7'h00, irq_out}, 8'h00);
        wr(OFS_DATA, 8'h1E);
        chk(OFS_DATA, 8'hA1);
        for (int i = 0; i < 400 && got_vld !== 1'b1; i++) @(posedge clk_in);
        cmp(got, 8'h1E);
        wr(OFS_IID, 8'h09);
        wr(OFS_IEN, 8'h05);
        u_peer.send(8'h96, 1'b1);
        wait_irq();
        chk(OFS_IID, 8'hC6);
        rd(OFS_LST, d);
        cmp(d, 8'hE9);
        chk(OFS_IID, 8'hC4);
        chk(OFS_DATA, 8'h96);
        chk(OFS_IID, 8'hC1);
        wr(OFS_IID, 8'h41);
        u_peer.send(8'h11, 1'b0);
        chk(OFS_IID, 8'hC1);
        for (int i = 0; i < 3; i++) u_peer.send(8'h22, 1'b0);
        wait_irq();
        chk(OFS_IID, 8'hC4);
        wr(OFS_IID, 8'h43);
        chk(OFS_LST, 8'h60);
        wr(OFS_IEN, 8'h08);
        cts_n_in <= 1'b0;
        wait_irq();
        chk(OFS_IID, 8'hC0);
        chk(OFS_MST, 8'h11);
        @(posedge clk_in);
        cmp({7'h00, irq_out}, 8'h00);
        summarize();
    end
endmodule
